//--- core/pwmfs_regs.svh
// register map, field positions and reset values of the pwm fault sequencer
// assumes a 32-bit apb bus with word-aligned byte addresses
`ifndef PWMFS_REGS_SVH
`define PWMFS_REGS_SVH
`define PWMFS_CTRL_OFS       12'h000
`define PWMFS_PERIOD_OFS     12'h004
`define PWMFS_BLANK_OFS      12'h008
`define PWMFS_DUTY_OFS       12'h00c
`define PWMFS_SS_STEP_OFS    12'h010
`define PWMFS_STATUS_OFS     12'h014
`define PWMFS_CAUSE_OFS      12'h018
`define PWMFS_PCOUNT_OFS     12'h01c
`define PWMFS_CTRL_STOP_BIT  0
`define PWMFS_ST_START_BIT   0
`define PWMFS_ST_FAULT_BIT   1
`define PWMFS_ST_PERMIT_BIT  2
`define PWMFS_ST_CMP_BIT     3
`define PWMFS_ST_SSCLAMP_BIT 4
`define PWMFS_ST_PWM_BIT     5
`define PWMFS_ST_OSC_BIT     6
`define PWMFS_ST_SS_LSB      16
`define PWMFS_CAUSE_UV_BIT   3
`define PWMFS_PERIOD_RST     16'h0064
`define PWMFS_BLANK_RST      16'h0005
`define PWMFS_DUTY_RST       16'h0050
`define PWMFS_SS_STEP_RST    16'h0001
`define PWMFS_LEVEL_MAX      16'hffff
`endif

//--- core/pwmfs_pkg.sv
// types and a helper function shared by the pwm fault sequencer modules
// assumes nothing beyond a systemverilog compiler
package pwmfs_pkg;
	typedef enum logic [3:0] {
		PWMFS_R_CTRL,
		PWMFS_R_PERIOD,
		PWMFS_R_BLANK,
		PWMFS_R_DUTY,
		PWMFS_R_SS_STEP,
		PWMFS_R_STATUS,
		PWMFS_R_CAUSE,
		PWMFS_R_PCOUNT,
		PWMFS_R_NONE
	} pwmfs_reg_t;

	typedef enum logic [1:0] {
		PWMFS_BLANKED,
		PWMFS_PULSING,
		PWMFS_DONE
	} pwmfs_lat_t;

	function automatic logic [15:0] pwmfs_min3(input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c);
		logic [15:0] m;
		m = (a < b) ? a : b;
		return (c < m) ? c : m;
	endfunction
endpackage

//--- core/pwmfs_if.sv
// carriers between the top and its two sub-blocks
// assumes all signals are synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
interface pwmfs_seq_if;
	logic       cmp;
	logic       reset_pin;
	logic [2:0] fault_req;
	logic       start_flag;
	logic       fault_hold;
	logic       restart_permit;
	logic       uv_event;
	modport seq (input cmp, reset_pin, fault_req,
		output start_flag, fault_hold, restart_permit, uv_event);
	modport core (output cmp, reset_pin, fault_req,
		input start_flag, fault_hold, restart_permit, uv_event);
endinterface

interface pwmfs_lat_if;
	logic clk_pulse;
	logic term;
	logic pulse_on;
	logic pulse_start;
	modport lat (input clk_pulse, term, output pulse_on, pulse_start);
	modport core (output clk_pulse, term, input pulse_on, pulse_start);
endinterface
`default_nettype wire

//--- core/pwmfs_fault_seq.sv
// fault sequencer: start, fault-hold and restart-permit flags
// assumes comparator, reset pin and fault requests already synchronous
`timescale 1ns/10ps
`default_nettype none
module pwmfs_fault_seq (
	input wire logic pclk,
	input wire logic presetn,
	pwmfs_seq_if.seq sq
);
	logic next_start;
	logic next_fault;
	logic next_permit;
	logic uv_fault;
	logic restart_clear_gate;

	always_comb begin
		// undervoltage only counts once the start flag is up
		uv_fault = sq.start_flag & ~sq.cmp;
		restart_clear_gate = sq.restart_permit & ~sq.cmp;
		sq.uv_event = uv_fault;
		if (restart_clear_gate) begin
			// clear dominates while the comparator stays low
			next_start = 1'b0;
			next_fault = 1'b0;
		end else begin
			next_start = sq.start_flag | sq.cmp;
			// momentary request is enough; re-sets at once if fault persists
			next_fault = sq.fault_hold | (|sq.fault_req) | uv_fault;
		end
		if (!sq.fault_hold) begin
			next_permit = 1'b0;
		end else begin
			// low level or low pulse sets; high pin never sets it
			next_permit = sq.restart_permit | ~sq.reset_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq.start_flag     <= 1'b0;
			sq.fault_hold     <= 1'b0;
			sq.restart_permit <= 1'b0;
		end else begin
			sq.start_flag     <= next_start;
			sq.fault_hold     <= next_fault;
			sq.restart_permit <= next_permit;
		end
	end
endmodule
`default_nettype wire

//--- core/pwmfs_pulse_latch.sv
// pulse latch: one output pulse per oscillator period
// assumes clk_pulse is held high whenever the oscillator is stopped
`timescale 1ns/10ps
`default_nettype none
module pwmfs_pulse_latch (
	input wire logic pclk,
	input wire logic presetn,
	pwmfs_lat_if.lat lt
);
	pwmfs_pkg::pwmfs_lat_t state;
	pwmfs_pkg::pwmfs_lat_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			pwmfs_pkg::PWMFS_BLANKED: begin
				if (!lt.clk_pulse && !lt.term) begin
					next_state = pwmfs_pkg::PWMFS_PULSING;
				end else if (!lt.clk_pulse) begin
					next_state = pwmfs_pkg::PWMFS_DONE;
				end
			end
			pwmfs_pkg::PWMFS_PULSING: begin
				if (lt.clk_pulse) begin
					next_state = pwmfs_pkg::PWMFS_BLANKED;
				end else if (lt.term) begin
					next_state = pwmfs_pkg::PWMFS_DONE;
				end
			end
			pwmfs_pkg::PWMFS_DONE: begin
				// comparator chatter ignored until the next clock pulse
				if (lt.clk_pulse) begin
					next_state = pwmfs_pkg::PWMFS_BLANKED;
				end
			end
			default: next_state = pwmfs_pkg::PWMFS_BLANKED;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= pwmfs_pkg::PWMFS_BLANKED;
		end else begin
			state <= next_state;
		end
	end

	assign lt.pulse_on = (state == pwmfs_pkg::PWMFS_PULSING);
	assign lt.pulse_start = (state == pwmfs_pkg::PWMFS_BLANKED) &&
		(next_state == pwmfs_pkg::PWMFS_PULSING);
endmodule
`default_nettype wire

//--- core/pwmfs_top.sv
// pwm fault sequencer top: apb registers, oscillator, ramp, slow start
// assumes all pins synchronous to pclk; comparators are digital levels
//
// Operation
// - pulse starts when clock pulse ends, stops when ramp crosses lowest threshold.
// - clock pulse blanks output low so duty never reaches full period.
// - pulse latch gives one pulse per period, ignores comparator chatter.
// - below start level arming off and switch clamp on.
// - start indication enables arming and releases slow-start clamp together.
// - any momentary fault request sets the fault-hold flag, which stays set until permit plus low comparator clears it.
// - start flag cleared at power-up; undervoltage then ignored.
// - first start level sets start flag without any undervoltage fault.
// - undervoltage fault only when comparator falls with start flag set.
// - restart permit held clear while fault-hold is clear.
// - with fault-hold set, a low reset pin sets the permit, which then stays set until fault-hold clears.
// - a short low pulse on reset pin sets the permit.
// - permit plus low comparator clears fault-hold and start flag.
// - persisting fault sets fault-hold again as soon as clear ends.
// - reset pin wiring selects latch-off, restart, limited retry or pulse reset.
// - reset pin high (external charge reaches threshold) keeps output locked off.
// - arming output keeps cycling with the comparator while latched off.
// - slow-start node held low before start and while fault latched.
// - oscillator idle until comparator gives the start command.
`timescale 1ns/10ps
`default_nettype none
`include "pwmfs_regs.svh"
module pwmfs_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vin_ok,
	input  wire logic        supply_level_comparator,
	input  wire logic        reset_pin,
	input  wire logic [1:0]  fault_pin,
	input  wire logic [15:0] err_level,
	output logic             pwm_out,
	output logic             arming_source_on,
	output logic             switch_clamp_on,
	output logic             slow_start_clamp,
	output logic             osc_run
);
	pwmfs_seq_if sq ();
	pwmfs_lat_if lt ();

	logic        ext_stop;
	logic [15:0] period;
	logic [15:0] blank;
	logic [15:0] duty_limit;
	logic [15:0] ss_step;
	logic [3:0]  cause;
	logic [15:0] pulse_count;
	logic [31:0] next_prdata;
	logic        next_ext_stop;
	logic [15:0] next_period;
	logic [15:0] next_blank;
	logic [15:0] next_duty_limit;
	logic [15:0] next_ss_step;
	logic [3:0]  next_cause;
	logic [15:0] next_pulse_count;

	logic [15:0] osc_cnt;
	logic [15:0] ss_level;
	logic [15:0] next_osc_cnt;
	logic [15:0] next_ss_level;
	logic        period_end;
	logic [15:0] ramp;
	logic [15:0] threshold;
	logic [16:0] ss_sum;

	pwmfs_pkg::pwmfs_reg_t sel_reg;
	logic        wr_en;
	logic        rd_setup;
	logic [31:0] status_word;
	logic [3:0]  cause_clr;
	logic [3:0]  cause_set;

	function automatic pwmfs_pkg::pwmfs_reg_t decode(input logic [31:0] a);
		pwmfs_pkg::pwmfs_reg_t r;
		r = pwmfs_pkg::PWMFS_R_NONE;
		if (a[31:12] == 20'h00000 && a[1:0] == 2'h0) begin
			case (a[11:0])
				`PWMFS_CTRL_OFS:    r = pwmfs_pkg::PWMFS_R_CTRL;
				`PWMFS_PERIOD_OFS:  r = pwmfs_pkg::PWMFS_R_PERIOD;
				`PWMFS_BLANK_OFS:   r = pwmfs_pkg::PWMFS_R_BLANK;
				`PWMFS_DUTY_OFS:    r = pwmfs_pkg::PWMFS_R_DUTY;
				`PWMFS_SS_STEP_OFS: r = pwmfs_pkg::PWMFS_R_SS_STEP;
				`PWMFS_STATUS_OFS:  r = pwmfs_pkg::PWMFS_R_STATUS;
				`PWMFS_CAUSE_OFS:   r = pwmfs_pkg::PWMFS_R_CAUSE;
				`PWMFS_PCOUNT_OFS:  r = pwmfs_pkg::PWMFS_R_PCOUNT;
				default:            r = pwmfs_pkg::PWMFS_R_NONE;
			endcase
		end
		return r;
	endfunction

	pwmfs_fault_seq u_seq (
		.pclk    (pclk),
		.presetn (presetn),
		.sq      (sq.seq)
	);

	pwmfs_pulse_latch u_lat (
		.pclk    (pclk),
		.presetn (presetn),
		.lt      (lt.lat)
	);

	// sequencer inputs: two pin faults, software stop, undervoltage inside
	assign sq.cmp = supply_level_comparator;
	assign sq.reset_pin = reset_pin;
	assign sq.fault_req = {ext_stop, fault_pin};

	// zero-wait slave; read data captured in the setup phase
	assign pready = 1'b1;
	assign sel_reg = decode(paddr);
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pslverr = psel & penable & (sel_reg == pwmfs_pkg::PWMFS_R_NONE);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`PWMFS_ST_START_BIT] = sq.start_flag;
		status_word[`PWMFS_ST_FAULT_BIT] = sq.fault_hold;
		status_word[`PWMFS_ST_PERMIT_BIT] = sq.restart_permit;
		status_word[`PWMFS_ST_CMP_BIT] = supply_level_comparator;
		status_word[`PWMFS_ST_SSCLAMP_BIT] = slow_start_clamp;
		status_word[`PWMFS_ST_PWM_BIT] = pwm_out;
		status_word[`PWMFS_ST_OSC_BIT] = osc_run;
		status_word[`PWMFS_ST_SS_LSB +: 16] = ss_level;
	end

	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (sel_reg)
				pwmfs_pkg::PWMFS_R_CTRL:    next_prdata = {31'h0, ext_stop};
				pwmfs_pkg::PWMFS_R_PERIOD:  next_prdata = {16'h0, period};
				pwmfs_pkg::PWMFS_R_BLANK:   next_prdata = {16'h0, blank};
				pwmfs_pkg::PWMFS_R_DUTY:    next_prdata = {16'h0, duty_limit};
				pwmfs_pkg::PWMFS_R_SS_STEP: next_prdata = {16'h0, ss_step};
				pwmfs_pkg::PWMFS_R_STATUS:  next_prdata = status_word;
				pwmfs_pkg::PWMFS_R_CAUSE:   next_prdata = {28'h0, cause};
				pwmfs_pkg::PWMFS_R_PCOUNT:  next_prdata = {16'h0, pulse_count};
				default:                    next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		next_ext_stop = ext_stop;
		next_period = period;
		next_blank = blank;
		next_duty_limit = duty_limit;
		next_ss_step = ss_step;
		cause_clr = 4'h0;
		if (wr_en) begin
			case (sel_reg)
				pwmfs_pkg::PWMFS_R_CTRL:    next_ext_stop = pwdata[`PWMFS_CTRL_STOP_BIT];
				pwmfs_pkg::PWMFS_R_PERIOD:  next_period = pwdata[15:0];
				pwmfs_pkg::PWMFS_R_BLANK:   next_blank = pwdata[15:0];
				pwmfs_pkg::PWMFS_R_DUTY:    next_duty_limit = pwdata[15:0];
				pwmfs_pkg::PWMFS_R_SS_STEP: next_ss_step = pwdata[15:0];
				pwmfs_pkg::PWMFS_R_CAUSE:   cause_clr = pwdata[3:0];
				default:                    cause_clr = 4'h0;
			endcase
		end
		// sticky cause bits: a new event beats a write-one clear
		cause_set = {sq.uv_event, sq.fault_req};
		next_cause = (cause & ~cause_clr) | cause_set;
		next_pulse_count = pulse_count;
		if (lt.pulse_start) begin
			next_pulse_count = pulse_count + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h0000_0000;
			ext_stop    <= 1'b0;
			period      <= `PWMFS_PERIOD_RST;
			blank       <= `PWMFS_BLANK_RST;
			duty_limit  <= `PWMFS_DUTY_RST;
			ss_step     <= `PWMFS_SS_STEP_RST;
			cause       <= 4'h0;
			pulse_count <= 16'h0000;
		end else begin
			prdata      <= next_prdata;
			ext_stop    <= next_ext_stop;
			period      <= next_period;
			blank       <= next_blank;
			duty_limit  <= next_duty_limit;
			ss_step     <= next_ss_step;
			cause       <= next_cause;
			pulse_count <= next_pulse_count;
		end
	end

	// oscillator sleeps until the start command to save start-up current
	assign osc_run = supply_level_comparator | sq.start_flag;
	assign period_end = (osc_cnt >= period - 16'h0001);
	// stopped oscillator counts as one long blanking pulse
	assign lt.clk_pulse = ~osc_run | (osc_cnt < blank);
	assign ramp = osc_cnt - blank;
	// slow-start level of zero ends every pulse at once
	assign threshold = pwmfs_pkg::pwmfs_min3(err_level, ss_level, duty_limit);
	assign lt.term = (ramp >= threshold);
	assign ss_sum = {1'b0, ss_level} + {1'b0, ss_step};

	always_comb begin
		next_osc_cnt = osc_cnt;
		if (!osc_run || period_end) begin
			next_osc_cnt = 16'h0000;
		end else begin
			next_osc_cnt = osc_cnt + 16'h0001;
		end
		next_ss_level = ss_level;
		if (slow_start_clamp) begin
			next_ss_level = 16'h0000;
		end else if (osc_run && period_end) begin
			// saturate so a long run never wraps back to zero width
			next_ss_level = ss_sum[16] ? `PWMFS_LEVEL_MAX : ss_sum[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_cnt  <= 16'h0000;
			ss_level <= 16'h0000;
		end else begin
			osc_cnt  <= next_osc_cnt;
			ss_level <= next_ss_level;
		end
	end

	// clamp released in the same cycle that arming turns on
	assign slow_start_clamp = ~supply_level_comparator | sq.fault_hold;
	// arming tracks the comparator even while latched off
	assign arming_source_on = vin_ok & supply_level_comparator;
	assign pwm_out = lt.pulse_on;
	// clamp holds the switch off except during a pulse
	assign switch_clamp_on = vin_ok & ~lt.pulse_on;
endmodule
`default_nettype wire

//--- bench/pwmfs_sva.sv
// checker: port timing of the pwm fault sequencer
// assumes binding to pwmfs_top, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module pwmfs_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       vin_ok,
	input wire logic       supply_level_comparator,
	input wire logic [1:0] fault_pin,
	input wire logic       pwm_out,
	input wire logic       arming_source_on,
	input wire logic       switch_clamp_on,
	input wire logic       slow_start_clamp,
	input wire logic       osc_run
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence fault_seen;
		fault_pin != 2'b00 && supply_level_comparator;
	endsequence
	sequence clamp_held;
		slow_start_clamp [*2];
	endsequence
	arm_follow_a: assert property (arming_source_on == (vin_ok && supply_level_comparator))
		else $error("arming wrong");
	sw_clamp_a: assert property (vin_ok && !pwm_out |-> switch_clamp_on)
		else $error("switch clamp off");
	ss_low_a: assert property (!supply_level_comparator |-> slow_start_clamp)
		else $error("slow start free");
	fault_latch_a: assert property (fault_seen |=> slow_start_clamp)
		else $error("fault not held");
	no_pulse_a: assert property (clamp_held ##1 slow_start_clamp |-> !pwm_out)
		else $error("pulse under clamp");
	osc_start_a: assert property ($rose(osc_run) |-> supply_level_comparator)
		else $error("osc early");
	osc_idle_a: assert property (!osc_run [*2] |-> !pwm_out)
		else $error("pulse with osc off");
	pwm_start_a: assert property ($rose(pwm_out) |-> $past(osc_run))
		else $error("pulse in blanking");
endmodule
bind pwmfs_top pwmfs_sva u_sva (.pclk, .presetn, .vin_ok, .supply_level_comparator,
	.fault_pin, .pwm_out, .arming_source_on, .switch_clamp_on, .slow_start_clamp, .osc_run);
`default_nettype wire

//--- bench/pwmfs_partner.sv
// supply comparators, reset terminal and power switch
// assumes the bench sets supply and reset wiring
`timescale 1ns/10ps
`default_nettype none
module pwmfs_partner #(
	parameter int RETRIES = 2
) (
	input  wire logic       pclk,
	input  wire logic       vin_on,
	input  wire logic       sup_up,
	input  wire logic       pull_dn,
	input  wire logic [1:0] rst_mode,
	input  wire logic       rst_pls,
	input  wire logic       arming_source_on,
	input  wire logic       switch_clamp_on,
	output logic            vin_ok,
	output logic            supply_level_comparator,
	output logic            reset_pin,
	output logic            switch_on
);
	int   n_arm = 0;
	logic arm_d = 1'b0;
	// charge pumped per arming turn-on
	always @(posedge pclk) begin
		arm_d <= arming_source_on;
		if (rst_mode != 2'd2)
			n_arm <= 0;
		else if (arming_source_on && !arm_d)
			n_arm <= n_arm + 1;
	end
	assign vin_ok = vin_on;
	assign supply_level_comparator = sup_up && !pull_dn;
	always_comb begin
		case (rst_mode)
			2'd0: reset_pin = 1'b0;
			2'd1: reset_pin = 1'b1;
			2'd2: reset_pin = n_arm >= RETRIES;
			default: reset_pin = !rst_pls;
		endcase
	end
	// clamp shunts the arming current
	assign switch_on = arming_source_on && !switch_clamp_on;
endmodule
`default_nettype wire

//--- bench/pwm_fault_sequencer_tb_top.sv
// testbench: apb access and fault sequencing of pwmfs_top
// assumes the partner model drives supply and reset pins
`timescale 1ns/10ps
`default_nettype none
`include "pwmfs_regs.svh"
module pwm_fault_sequencer_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [31:0] paddr, pwdata, prdata, q, p0;
	logic        vin_ok, supply_level_comparator, reset_pin, pwm_out, osc_run;
	logic        arming_source_on, switch_clamp_on, slow_start_clamp, sw_on;
	logic [1:0]  fault_pin, rst_mode;
	logic [15:0] err_level;
	logic        vin_on, sup_up, pull_dn, rst_pls;
	int          n_fail = 0, cmp_count = 0, cyc = 0, hi_run = 0, i, j;
	localparam logic [31:0] ALL = 32'hffffffff;
	pwmfs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .vin_ok, .supply_level_comparator, .reset_pin, .fault_pin,
		.err_level, .pwm_out, .arming_source_on, .switch_clamp_on, .slow_start_clamp, .osc_run);
	pwmfs_partner #(.RETRIES(2)) ptn (.pclk, .vin_on, .sup_up, .pull_dn, .rst_mode, .rst_pls,
		.arming_source_on, .switch_clamp_on, .vin_ok, .supply_level_comparator, .reset_pin,
		.switch_on(sw_on));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {20'h00000, a};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q & m, x);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic dip();
		pull_dn <= 1'b1;
		wt(3);
		pull_dn <= 1'b0;
		wt(3);
	endtask
	// timeout and pulse-width watch
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
		hi_run <= pwm_out ? hi_run + 1 : 0;
		if (presetn === 1'b1 && hi_run >= 20) begin
			n_fail++;
			$display("unexpected at %0t: pulse fills period", $time);
		end
		if (presetn === 1'b1 && sw_on !== (pwm_out && arming_source_on)) begin
			n_fail++;
			$display("unexpected at %0t: switch state", $time);
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, vin_on, sup_up, pull_dn, rst_pls} = '0;
		presetn = 1'b0;
		rst_mode = 2'd0;
		fault_pin = 2'b00;
		err_level = 16'hffff;
		wt(6);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`PWMFS_PERIOD_OFS, ALL, {16'h0000, `PWMFS_PERIOD_RST});
		rdc(`PWMFS_BLANK_OFS, ALL, {16'h0000, `PWMFS_BLANK_RST});
		rdc(`PWMFS_DUTY_OFS, ALL, {16'h0000, `PWMFS_DUTY_RST});
		rdc(`PWMFS_SS_STEP_OFS, ALL, {16'h0000, `PWMFS_SS_STEP_RST});
		rdc(12'h020, ALL, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, `PWMFS_PERIOD_OFS, 32'd20);
		apb(1'b1, `PWMFS_BLANK_OFS, 32'd4);
		apb(1'b1, `PWMFS_SS_STEP_OFS, 32'h10);
		apb(1'b1, `PWMFS_DUTY_OFS, 32'hffff);
		vin_on <= 1'b1;
		rdc(`PWMFS_STATUS_OFS, 32'h7f, 32'h10);
		// low comparator before start must not log an undervoltage cause
		rdc(`PWMFS_CAUSE_OFS, 32'hf, 32'h0);
		sup_up <= 1'b1;
		wt(3);
		rdc(`PWMFS_STATUS_OFS, 32'h5f, 32'h49);
		// chatter on the second window: latch must give at most one pulse per period
		for (j = 0; j < 2; j++) begin
			wt(40);
			apb(1'b0, `PWMFS_PCOUNT_OFS, 32'h0);
			p0 = q;
			for (i = 0; i < 200; i++) begin
				@(posedge pclk);
				if (j == 1)
					err_level <= ~err_level;
			end
			apb(1'b0, `PWMFS_PCOUNT_OFS, 32'h0);
			chk(32'((q - p0) <= 11 && (j == 1 || (q - p0) >= 9)), 32'h1);
		end
		rst_mode <= 2'd3;
		for (i = 0; i < 3; i++) begin
			if (i < 2) begin
				fault_pin[i] <= 1'b1;
				@(posedge pclk);
				fault_pin <= 2'b00;
			end else begin
				apb(1'b1, `PWMFS_CTRL_OFS, 32'h1);
				apb(1'b1, `PWMFS_CTRL_OFS, 32'h0);
			end
			wt(3);
			rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h3);
			// dips of the previous pass left the undervoltage cause set
			rdc(`PWMFS_CAUSE_OFS, 32'hf, (i == 0) ? 32'h1 : (32'h8 | (32'h1 << i)));
			apb(1'b1, `PWMFS_CAUSE_OFS, 32'hf);
			dip();
			rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h3);
			rst_pls <= 1'b1;
			@(posedge pclk);
			rst_pls <= 1'b0;
			wt(2);
			rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h7);
			pull_dn <= 1'b1;
			wt(3);
			rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h0);
			pull_dn <= 1'b0;
			wt(3);
			rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h1);
		end
		// clear leftovers so only this dip can set the undervoltage cause
		apb(1'b1, `PWMFS_CAUSE_OFS, 32'hf);
		rst_mode <= 2'd0;
		dip();
		rdc(`PWMFS_CAUSE_OFS, 32'h8, 32'h8);
		fault_pin <= 2'b10;
		dip();
		rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h7);
		fault_pin <= 2'b01;
		rst_mode <= 2'd2;
		repeat (4) dip();
		rdc(`PWMFS_STATUS_OFS, 32'h7, 32'h3);
		chk({31'h0, arming_source_on}, 32'h1);
		finish_test();
	end
endmodule
`default_nettype wire
